// ### verilog/hcad_core.sv
// Contract
// [RL1] separate program and data buses
// [RL2] 12-bit instruction word fetched per cycle
// [RL3] two-stage fetch/execute pipeline
// [RL4] one cycle each, branches take two
// [RL5] 8-bit add, subtract, shift, logic ALU
// [RL6] arithmetic in two's complement
// [RL7] two operands: W with file or literal
// [RL8] single operand: W or file register
// [RL9] W feeds ALU, has no file address
// [RL10] ALU updates carry, nibble carry, zero
// [RL11] subtract carries are inverted borrows
// [RL12] SFRs and PC mapped, direct and indirect
// [RL13] zero on all-zero result, nibble carry
//
// Local design decisions: strobed register access and the register offsets.
`timescale 1ns/1ps
module hcad_core
  import hcad_pkg::*;
#(
  parameter int RAM_WORDS = RAM_DEPTH
)
(
  input  wire logic              clk,
  input  wire logic              rst,
  output logic      [PC_W-1:0]   prog_addr,
  input  wire logic [INSN_W-1:0] prog_data,
  input  wire hcad_host_req_type host_req,
  output logic      [DATA_W-1:0] host_rdata
);
  logic [PC_W-1:0]    pc;
  logic [INSN_W-1:0]  ir;
  logic               ir_valid;
  logic [DATA_W-1:0]  w;
  logic [DATA_W-1:0]  fsr;
  logic               carry_flag;
  logic               nibble_carry_flag;
  logic               zero_flag;
  logic               run;

  hcad_insn_type      insn;
  logic [DATA_W-1:0]  lit;
  logic               exec;
  logic [FADDR_W-1:0] eff_faddr;
  logic [DATA_W-1:0]  ram_q;
  logic [DATA_W-1:0]  file_val;
  logic [DATA_W-1:0]  operand_b;
  logic [DATA_W-1:0]  status_view;
  hcad_alu_op_type    alu_op;
  hcad_alu_out_type   alu_out;
  logic               wr_file;
  logic               wr_w;
  logic               upd_z;
  logic               upd_c;
  logic               upd_dc;
  logic               jump;
  logic               pcl_write;
  logic               branch_now;
  logic [PC_W-1:0]    next_pc;
  logic               ram_we;

  assign prog_addr = pc;
  assign insn      = hcad_insn_type'(ir);
  assign lit       = ir[DATA_W-1:0];
  assign exec      = run && ir_valid;

  // indirect access through the pointer register
  assign eff_faddr = (insn.faddr == SFR_INDF) ? fsr[FADDR_W-1:0] : insn.faddr;  // RL12

  // status as seen by file reads and the host
  always_comb begin
    status_view        = DATA_RESET;
    status_view[ST_C]  = carry_flag;
    status_view[ST_DC] = nibble_carry_flag;
    status_view[ST_Z]  = zero_flag;
  end

  // file read mux: specials, then general purpose RAM
  always_comb begin
    case (eff_faddr)
      SFR_PCL:    file_val = pc[DATA_W-1:0];  // RL12
      SFR_STATUS: file_val = status_view;     // RL12
      SFR_FSR:    file_val = fsr;             // RL12
      default:    file_val = (eff_faddr >= GPR_BASE) ? ram_q : DATA_RESET;
    endcase
  end

  // decode: operand select, ALU op, destination, flag set
  always_comb begin
    alu_op    = ALU_PASS;
    operand_b = file_val;
    wr_file   = 1'b0;
    wr_w      = 1'b0;
    upd_z     = 1'b0;
    upd_c     = 1'b0;
    upd_dc    = 1'b0;
    jump      = 1'b0;
    case (insn.op)
      OP_ADDWF, OP_SUBWF: begin
        alu_op  = (insn.op == OP_ADDWF) ? ALU_ADD : ALU_SUB;  // RL5 RL6
        wr_file = insn.dest_f;
        wr_w    = !insn.dest_f;
        upd_z   = 1'b1;  // RL10
        upd_c   = 1'b1;
        upd_dc  = 1'b1;
      end
      OP_ANDWF, OP_IORWF, OP_XORWF: begin
        alu_op  = (insn.op == OP_ANDWF) ? ALU_AND :
                  (insn.op == OP_IORWF) ? ALU_IOR : ALU_XOR;  // RL7
        wr_file = insn.dest_f;
        wr_w    = !insn.dest_f;
        upd_z   = 1'b1;
      end
      OP_RLF, OP_RRF: begin
        alu_op    = (insn.op == OP_RLF) ? ALU_RL : ALU_RR;  // RL5
        operand_b = insn.src_w ? w : file_val;  // RL8
        wr_file   = insn.dest_f;
        wr_w      = !insn.dest_f;
        upd_c     = 1'b1;
      end
      OP_MOVF, OP_COMF: begin
        alu_op    = (insn.op == OP_COMF) ? ALU_COM : ALU_PASS;
        operand_b = insn.src_w ? w : file_val;  // RL8
        wr_file   = insn.dest_f;
        wr_w      = !insn.dest_f;
        upd_z     = 1'b1;
      end
      OP_MOVWF: begin
        operand_b = w;  // RL9
        wr_file   = 1'b1;
      end
      OP_GOTO: begin
        jump = 1'b1;
      end
      OP_MOVLW: begin
        operand_b = lit;  // RL7
        wr_w      = 1'b1;
      end
      OP_ANDLW, OP_IORLW, OP_XORLW: begin
        alu_op    = (insn.op == OP_ANDLW) ? ALU_AND :
                    (insn.op == OP_IORLW) ? ALU_IOR : ALU_XOR;
        operand_b = lit;  // RL7
        wr_w      = 1'b1;
        upd_z     = 1'b1;
      end
      default: begin
        jump = 1'b0;  // nop and reserved codes
      end
    endcase
  end

  hcad_alu u_alu (
    .op  (alu_op),
    .a   (w),
    .b   (operand_b),
    .cin (carry_flag),
    .y   (alu_out)
  );

  // data memory has its own port, apart from the program bus
  assign ram_we = exec && wr_file && (eff_faddr >= GPR_BASE);  // RL1

  hcad_ram #(
    .DEPTH (RAM_WORDS)
  ) u_ram (
    .clk   (clk),
    .we    (ram_we),
    .addr  (eff_faddr),
    .wdata (alu_out.res),
    .rdata (ram_q)
  );

  // a write to the PC low byte is a branch; upper PC bits clear
  assign pcl_write  = wr_file && (eff_faddr == SFR_PCL);  // RL12
  assign branch_now = exec && (jump || pcl_write);
  assign next_pc    = jump ? PC_W'(lit) : PC_W'(alu_out.res);

  // fetch side: PC walks one word per cycle unless halted or branching
  always_ff @(posedge clk) begin
    if (rst) begin
      pc <= PC_RESET;
    end else if (run) begin
      pc <= branch_now ? next_pc : pc + PC_W'(1);  // RL3
    end
  end

  // pipeline register; a branch kills the word already fetched
  always_ff @(posedge clk) begin
    if (rst) begin
      ir       <= INSN_NOP;
      ir_valid <= 1'b0;
    end else if (run) begin
      ir       <= prog_data;    // RL2
      ir_valid <= !branch_now;  // RL4
    end
  end

  // working register: only reached through the ALU result
  always_ff @(posedge clk) begin
    if (rst) begin
      w <= DATA_RESET;
    end else if (exec && wr_w) begin
      w <= alu_out.res;  // RL9
    end
  end

  // indirect pointer
  always_ff @(posedge clk) begin
    if (rst) begin
      fsr <= DATA_RESET;
    end else if (exec && wr_file && (eff_faddr == SFR_FSR)) begin
      fsr <= alu_out.res;
    end
  end

  // flags: ALU update wins over a plain write of the status file
  always_ff @(posedge clk) begin
    if (rst) begin
      carry_flag        <= 1'b0;
      nibble_carry_flag <= 1'b0;
      zero_flag         <= 1'b0;
    end else if (exec) begin
      if (wr_file && (eff_faddr == SFR_STATUS)) begin
        carry_flag        <= alu_out.res[ST_C];
        nibble_carry_flag <= alu_out.res[ST_DC];
        zero_flag         <= alu_out.res[ST_Z];
      end
      if (upd_c) begin
        carry_flag <= alu_out.carry;  // RL10 RL11
      end
      if (upd_dc) begin
        nibble_carry_flag <= alu_out.nib;  // RL11 RL13
      end
      if (upd_z) begin
        zero_flag <= alu_out.zero;  // RL13
      end
    end
  end

  // host control: run bit freezes fetch and execute together
  always_ff @(posedge clk) begin
    if (rst) begin
      run <= CTRL_RUN_RESET;
    end else if (host_req.wr && (host_req.addr == HOST_CTRL)) begin
      run <= host_req.wdata[CTRL_RUN];
    end
  end

  // host read data stands for exactly the cycle after the strobe
  always_ff @(posedge clk) begin
    if (rst) begin
      host_rdata <= DATA_RESET;
    end else if (host_req.rd) begin
      case (host_req.addr)
        HOST_CTRL:   host_rdata <= DATA_W'(run);
        HOST_W:      host_rdata <= w;  // RL9
        HOST_STATUS: host_rdata <= status_view;
        HOST_PC_LO:  host_rdata <= pc[DATA_W-1:0];
        HOST_PC_HI:  host_rdata <= DATA_W'(pc[PC_W-1:DATA_W]);
        default:     host_rdata <= DATA_RESET;
      endcase
    end else begin
      host_rdata <= DATA_RESET;
    end
  end

  // helper values for the checks below
  logic [DATA_W:0]    chk_sum;
  logic [NIB_MSB+1:0] chk_nib;
  assign chk_sum = {1'b0, file_val} + {1'b0, w};
  assign chk_nib = {1'b0, file_val[NIB_MSB:0]} + {1'b0, w[NIB_MSB:0]};

  // reset is released by a register at an edge; checks skip that edge as well
  logic chk_rst_q;
  always_ff @(posedge clk) begin
    chk_rst_q <= rst;
  end

  default clocking chk_cb @(posedge clk); endclocking
  default disable iff (rst || chk_rst_q);

  sequence s_branch;
    exec && branch_now;
  endsequence

  sequence s_bubble;
    !ir_valid && (pc == $past(next_pc));
  endsequence

  chk_pc_step: assert property (run && !branch_now |=> pc == $past(pc) + PC_W'(1))  // RL3
    else $error("pc did not step by one");

  chk_fetch_word: assert property (run && !branch_now |=> ir_valid && ir == $past(prog_data))  // RL2
    else $error("fetched word not loaded");

  chk_branch_bubble: assert property (s_branch |=> s_bubble)  // RL4
    else $error("branch did not flush or redirect");

  chk_zero_flag: assert property (exec && upd_z |=> zero_flag == ($past(alu_out.res) == DATA_RESET))  // RL13
    else $error("zero flag wrong");

  chk_sub_borrow: assert property (exec && insn.op == OP_SUBWF  // RL11
    |=> carry_flag == ($past(file_val) >= $past(w)))
    else $error("subtract carry not inverted borrow");

  chk_sub_nibble: assert property (exec && insn.op == OP_SUBWF  // RL11
    |=> nibble_carry_flag == ($past(file_val[NIB_MSB:0]) >= $past(w[NIB_MSB:0])))
    else $error("subtract nibble carry not inverted borrow");

  chk_add_carry: assert property (exec && insn.op == OP_ADDWF  // RL6
    |=> carry_flag == $past(chk_sum[DATA_W]) && (!$past(wr_w) || w == $past(chk_sum[DATA_W-1:0])))
    else $error("add result or carry wrong");

  chk_nib_carry: assert property (exec && insn.op == OP_ADDWF  // RL13
    |=> nibble_carry_flag == $past(chk_nib[NIB_MSB+1]))
    else $error("nibble carry wrong");

  chk_rl_carry: assert property (exec && insn.op == OP_RLF |=> carry_flag == $past(operand_b[DATA_W-1]))  // RL5
    else $error("rotate left carry wrong");

  chk_rr_carry: assert property (exec && insn.op == OP_RRF |=> carry_flag == $past(operand_b[0]))  // RL5
    else $error("rotate right carry wrong");

  chk_com_result: assert property (exec && insn.op == OP_COMF && !insn.dest_f |=> w == ~$past(operand_b))  // RL5
    else $error("complement result wrong");

  chk_and_file: assert property (exec && insn.op == OP_ANDWF && !insn.dest_f  // RL7
    |=> w == ($past(w) & $past(file_val)))
    else $error("and with file register wrong");

  chk_xor_literal: assert property (exec && insn.op == OP_XORLW |=> w == ($past(w) ^ $past(lit)))  // RL7
    else $error("xor with literal wrong");

  chk_w_hidden: assert property (!(exec && wr_w) |=> w == $past(w))  // RL9
    else $error("w changed without an alu write");

  chk_run_freeze: assert property (!run |=> pc == $past(pc) && ir == $past(ir))  // RL3
    else $error("halted core moved");

  chk_w_literal: assert property (exec && insn.op == OP_MOVLW |=> w == $past(lit))  // RL7
    else $error("literal not loaded to w");

  chk_host_read: assert property (host_req.rd && host_req.addr == HOST_W  // RL9
    |=> host_rdata == $past(w) ##1 ($past(host_req.rd) || host_rdata == DATA_RESET))
    else $error("host read of w wrong");

endmodule : hcad_core

// ### common/hcad_pkg.sv
package hcad_pkg;
  // core widths
  localparam int INSN_W    = 12;
  localparam int DATA_W    = 8;
  localparam int FADDR_W   = 5;
  localparam int PC_W      = 9;
  localparam int RAM_DEPTH = 32;
  localparam int NIB_MSB   = 3;

  // reset values
  localparam logic [PC_W-1:0]   PC_RESET       = 9'h000;
  localparam logic [INSN_W-1:0] INSN_NOP       = 12'h000;
  localparam logic [DATA_W-1:0] DATA_RESET     = 8'h00;
  localparam logic              CTRL_RUN_RESET = 1'b1;

  // file register map
  localparam logic [FADDR_W-1:0] SFR_INDF   = 5'h00;
  localparam logic [FADDR_W-1:0] SFR_PCL    = 5'h02;
  localparam logic [FADDR_W-1:0] SFR_STATUS = 5'h03;
  localparam logic [FADDR_W-1:0] SFR_FSR    = 5'h04;
  localparam logic [FADDR_W-1:0] GPR_BASE   = 5'h07;

  // status bit positions
  localparam int ST_C  = 0;
  localparam int ST_DC = 1;
  localparam int ST_Z  = 2;

  // host register map
  localparam int               HOST_ADDR_W = 3;
  localparam logic [HOST_ADDR_W-1:0] HOST_CTRL   = 3'h0;
  localparam logic [HOST_ADDR_W-1:0] HOST_W      = 3'h1;
  localparam logic [HOST_ADDR_W-1:0] HOST_STATUS = 3'h2;
  localparam logic [HOST_ADDR_W-1:0] HOST_PC_LO  = 3'h3;
  localparam logic [HOST_ADDR_W-1:0] HOST_PC_HI  = 3'h4;
  localparam int               CTRL_RUN    = 0;

  typedef enum logic [3:0] {
    OP_MISC, OP_ADDWF, OP_SUBWF, OP_ANDWF, OP_IORWF, OP_XORWF, OP_RLF, OP_RRF,
    OP_MOVF, OP_MOVWF, OP_COMF, OP_GOTO, OP_MOVLW, OP_ANDLW, OP_IORLW, OP_XORLW
  } hcad_op_type;

  typedef enum logic [3:0] {
    ALU_ADD, ALU_SUB, ALU_AND, ALU_IOR, ALU_XOR, ALU_RL, ALU_RR, ALU_PASS, ALU_COM
  } hcad_alu_op_type;

  typedef struct packed {
    hcad_op_type        op;
    logic               rsvd;
    logic               src_w;
    logic               dest_f;
    logic [FADDR_W-1:0] faddr;
  } hcad_insn_type;

  typedef struct packed {
    logic [DATA_W-1:0] res;
    logic              carry;
    logic              nib;
    logic              zero;
  } hcad_alu_out_type;

  typedef struct packed {
    logic                   wr;
    logic                   rd;
    logic [HOST_ADDR_W-1:0] addr;
    logic [DATA_W-1:0]      wdata;
  } hcad_host_req_type;
endpackage : hcad_pkg

// ### verilog/hcad_alu.sv
`timescale 1ns/1ps
module hcad_alu
  import hcad_pkg::*;
(
  input  wire hcad_alu_op_type  op,
  input  wire logic [DATA_W-1:0] a,
  input  wire logic [DATA_W-1:0] b,
  input  wire logic              cin,
  output hcad_alu_out_type       y
);
  logic [DATA_W:0]  full;
  logic [NIB_MSB+1:0] low;

  // a is always the working register, b the file, the literal or W
  always_comb begin
    full = '0;
    low  = '0;
    case (op)
      ALU_ADD: begin
        full = {1'b0, a} + {1'b0, b};
        low  = {1'b0, a[NIB_MSB:0]} + {1'b0, b[NIB_MSB:0]};
      end
      ALU_SUB: begin
        // b - a as b + ~a + 1: carry out is the inverted borrow
        full = {1'b0, b} + {1'b0, ~a} + (DATA_W+1)'(1);
        low  = {1'b0, b[NIB_MSB:0]} + {1'b0, ~a[NIB_MSB:0]} + (NIB_MSB+2)'(1);
      end
      ALU_AND:  full = {1'b0, a & b};
      ALU_IOR:  full = {1'b0, a | b};
      ALU_XOR:  full = {1'b0, a ^ b};
      ALU_RL:   full = {b, cin};
      ALU_RR:   full = {b[0], cin, b[DATA_W-1:1]};
      ALU_COM:  full = {1'b0, ~b};
      ALU_PASS: full = {1'b0, b};
      default:  full = {1'b0, b};
    endcase
    y.res   = full[DATA_W-1:0];
    y.carry = full[DATA_W];
    y.nib   = low[NIB_MSB+1];
    y.zero  = (full[DATA_W-1:0] == DATA_RESET);
  end
endmodule : hcad_alu

// ### verilog/hcad_ram.sv
`timescale 1ns/1ps
module hcad_ram
  import hcad_pkg::*;
#(
  parameter int DEPTH = RAM_DEPTH
)
(
  input  wire logic               clk,
  input  wire logic               we,
  input  wire logic [FADDR_W-1:0] addr,
  input  wire logic [DATA_W-1:0]  wdata,
  output logic      [DATA_W-1:0]  rdata
);
  logic [DATA_W-1:0] mem [DEPTH];

  // no reset: contents are undefined until software writes them
  always_ff @(posedge clk) begin
    if (we) begin
      mem[addr] <= wdata;
    end
  end

  // read is combinational so an operand is ready in its execute cycle
  assign rdata = mem[addr];
endmodule : hcad_ram

// ### verif/hcad_prog_rom.sv
`timescale 1ns/1ps
module hcad_prog_rom
  import hcad_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              ld_en,
  input  wire logic [PC_W-1:0]   ld_addr,
  input  wire logic [INSN_W-1:0] ld_data,
  input  wire logic [PC_W-1:0]   addr,
  output logic      [INSN_W-1:0] data
);
  logic [INSN_W-1:0] mem [0:(1<<PC_W)-1];

  // bench patches words at run time, e.g. to lift a stop loop
  always @(posedge clk) begin
    if (ld_en) begin
      mem[ld_addr] <= ld_data;
    end
  end

  // asynchronous read: the core takes the whole word in the same cycle
  assign data = mem[addr];
endmodule : hcad_prog_rom

// ### verif/tb_top.sv
`timescale 1ns/1ps
module tb_top
  import hcad_pkg::*;
;
  logic                  clk = 1'b0;
  logic                  rst = 1'b1;
  logic                  ld_en = 1'b0;
  logic [PC_W-1:0]       ld_addr = '0;
  logic [INSN_W-1:0]     ld_data = '0;
  logic [PC_W-1:0]       prog_addr;
  logic [INSN_W-1:0]     prog_data;
  hcad_host_req_type     host_req = '0;
  logic [DATA_W-1:0]     host_rdata;
  logic [DATA_W-1:0]     v;
  logic [DATA_W-1:0]     a;
  int                    err_total = 0;
  int                    n_tests = 0;

  // program: five segments, each ending in a goto-self stop word
  localparam logic [INSN_W-1:0] PROG [0:34] = '{
    12'hC0F, 12'h927, 12'hC01, 12'h107, 12'hB04,
    12'hC0F, 12'h227, 12'h807, 12'hB08,
    12'hC01, 12'h207, 12'hB0B,
    12'hC07, 12'h924, 12'hC5A, 12'h920, 12'hC00, 12'h800, 12'hB14, 12'hC33, 12'hB14,
    12'hCA5, 12'h927, 12'hC0F, 12'h307, 12'h527, 12'hA07, 12'h647,
    12'h647, 12'h747, 12'h647, 12'h407, 12'hF0F, 12'hDF0, 12'hB22};

  hcad_prog_rom rom (
    .clk     (clk),
    .ld_en   (ld_en),
    .ld_addr (ld_addr),
    .ld_data (ld_data),
    .addr    (prog_addr),
    .data    (prog_data)
  );

  hcad_core DUT (
    .clk        (clk),
    .rst        (rst),
    .prog_addr  (prog_addr),
    .prog_data  (prog_data),
    .host_req   (host_req),
    .host_rdata (host_rdata)
  );

  // free-running core clock, 20 ns period
  initial begin
    forever #10 clk = ~clk;
  end

  task automatic complete_run();
    if (err_total == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : complete_run

  task automatic chk(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic host_wr(input logic [HOST_ADDR_W-1:0] ad, input logic [DATA_W-1:0] d);
    @(posedge clk);
    host_req.wr    <= 1'b1;
    host_req.addr  <= ad;
    host_req.wdata <= d;
    @(posedge clk);
    host_req.wr    <= 1'b0;
  endtask : host_wr

  // read data stand only in the cycle after the strobe
  task automatic host_rd(input logic [HOST_ADDR_W-1:0] ad, output logic [DATA_W-1:0] d);
    @(posedge clk);
    host_req.rd   <= 1'b1;
    host_req.addr <= ad;
    @(posedge clk);
    host_req.rd   <= 1'b0;
    #1 d = host_rdata;
  endtask : host_rd

  task automatic patch(input int k, input logic [INSN_W-1:0] w);
    @(posedge clk);
    ld_en   <= 1'b1;
    ld_addr <= k[PC_W-1:0];
    ld_data <= w;
    @(posedge clk);
    ld_en   <= 1'b0;
  endtask : patch

  // poll the program counter until the core sits in the stop loop at k
  task automatic run_to(input int k);
    logic [DATA_W-1:0] pc;
    int                i;
    for (i = 0; i < 60; i++) begin
      host_rd(HOST_PC_LO, pc);
      if (pc === k[7:0] || pc === k[7:0] + 8'h01) break;
    end
    if (i == 60) begin
      err_total++;
      complete_run();
    end else begin
      repeat (2) @(posedge clk);
    end
  endtask : run_to

  // main sequence
  initial begin
    for (int i = 0; i < (1 << PC_W); i++) begin
      rom.mem[i] = (i < 35) ? PROG[i] : INSN_NOP;
    end
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    host_rd(HOST_CTRL, v);
    chk(v, 8'h01);
    host_rd(3'h5, v);
    chk(v, 8'h00);
    run_to(4);
    host_rd(HOST_W, v);
    chk(v, 8'h10);
    host_rd(HOST_STATUS, v);
    chk(v, 8'h02);
    host_rd(HOST_PC_HI, v);
    chk(v, 8'h00);
    host_wr(HOST_W, 8'hAA);
    host_rd(HOST_W, v);
    chk(v, 8'h10);
    patch(4, INSN_NOP);
    run_to(8);
    host_rd(HOST_W, v);
    chk(v, 8'h00);
    host_rd(HOST_STATUS, v);
    chk(v, 8'h07);
    patch(8, INSN_NOP);
    run_to(11);
    host_rd(HOST_W, v);
    chk(v, 8'hFF);
    host_rd(HOST_STATUS, v);
    chk(v, 8'h00);
    patch(11, INSN_NOP);
    run_to(20);
    host_rd(HOST_W, v);
    chk(v, 8'h5A);
    host_rd(HOST_STATUS, v);
    chk(v, 8'h00);
    // logic, complement and rotate-through-carry segment
    patch(20, INSN_NOP);
    run_to(34);
    host_rd(HOST_W, v);
    chk(v, 8'hF0);
    host_rd(HOST_STATUS, v);
    chk(v, 8'h01);
    // stopped core must keep its program counter
    host_wr(HOST_CTRL, 8'h00);
    host_rd(HOST_PC_LO, a);
    repeat (3) @(posedge clk);
    host_rd(HOST_PC_LO, v);
    chk(v, a);
    host_rd(HOST_CTRL, v);
    chk(v, 8'h00);
    host_wr(HOST_CTRL, 8'h01);
    complete_run();
  end
endmodule : tb_top
